// ---- bus_control_unit.sv ----
// Bus control unit: setup registers over AHB-Lite, external access sequencing, DRAM refresh.
// Assumes one 20 MHz clock, a cold-start async reset and a same-domain hot-start pulse.
//
// Overview of operation
// (R01) Burst ROM beats after the first use only the burst-read wait.
// (R02) First burst ROM read and burst ROM writes use area wait; writes honour wait pin.
// (R03) Cold start sets area wait fields to seven; hot start keeps them.
// (R04) DRAM select bit picks DRAM for areas 8/7, or 14/13 when remapped.
// (R05) Burst select bit picks burst ROM for area 10, area 9 only unremapped.
// (R06) Burst reads insert zero to three waits from the burst-read field.
// (R07) Clock-hold bit or standby holds the bus clock pin high.
// (R08) Burst length bit selects eight or four beat burst reads.
// (R09) Page mode bit selects EDO or fast page for DRAM areas.
// (R10) Column width field maps to 8 to 11 bits and reads back.
// (R11) Refresh starts only when enabled and never in deep halt or sleep.
// (R12) CBR refresh starts one cycle per timer 0 underflow when method bit clear.
// (R13) Self-refresh starts with method bit set, ends when enable written zero.
// (R14) Precharge to CAS fall takes two cycles with delay bit, else one.
// (R15) CBR RAS pulse lasts two to five cycles from its field.
// (R16) Byte-select mode drives byte-select strobe for SRAM areas.
// (R17) Bus requests are granted only while external master bit is set.
// (R18) Power-down bit with bus request low halts the CPU.
// (R19) Wait pin sampled at each bus clock falling edge in SRAM cycles.
// (R20) External SRAM holds wait low until ready, then drives it high.
// (R21) Cold start clears select, burst, clock, refresh and bus control bits.
// (R22) SRAM accesses insert zero to seven waits from the area field.
// (R23) DRAM cycles get no area waits and ignore the wait pin.
// (R24) Wait pin ignored entirely while wait enable bit is clear.
// (R25) Timer refresh request during a bus cycle waits; only hot start or disabling refresh drops it.
//
// Our own choice: the AHB-Lite slave port.
`include "bus_control_unit_defines.svh"
module bus_control_unit (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic hot_start,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic acc_req,
  input wire logic [4:0] acc_area,
  input wire logic acc_write,
  input wire logic acc_low_byte,
  output logic acc_done,
  input wire logic timer0_underflow,
  input wire logic wait_n,
  input wire logic bus_request_n,
  output logic bus_grant_n,
  output logic cpu_halt,
  output logic bus_clock_out,
  output logic ras_n,
  output logic cas_n,
  output logic mem_rd_n,
  output logic mem_wr_n,
  output logic byte_select_low_n,
  output logic edo_page_select,
  output logic [3:0] column_addr_width
);
  localparam bus_control_unit_pkg::unit_state_t COLD = '{
    areas_14_13_setup: `RST_AREA, areas_10_9_setup: `RST_AREA, areas_8_7_setup: `RST_AREA,
    bus_control: `RST_BUS_CONTROL, mode_control: `RST_MODE_CONTROL,
    state: bus_control_unit_pkg::S_IDLE, cnt: 4'h0, beats: 3'h0,
    is_dram: 1'b0, is_burst: 1'b0, is_write: 1'b0, ext_ok: 1'b0, ref_pend: 1'b0,
    wait_sync: 3'h7, wait_f: 1'b1, breq_sync: 3'h7, breq_f: 1'b1, div: 1'b0,
    ahb_wr: 1'b0, ahb_rd: 1'b0, ahb_addr: 32'h0000_0000, hrdata: 32'h0000_0000,
    hreadyout: 1'b1, hresp: 1'b0, bus_clock_out: 1'b0, ras_n: 1'b1, cas_n: 1'b1,
    rd_n: 1'b1, wr_n: 1'b1, byte_sel_n: 1'b1, grant_n: 1'b1, cpu_halt: 1'b0,
    acc_done: 1'b0, edo: 1'b0, col_width: `COL_BASE};

  bus_control_unit_pkg::unit_state_t st_reg;
  bus_control_unit_pkg::unit_state_t st_next;
  logic standby;
  logic remap;
  logic ref_on;
  logic ref_self;
  logic ext_master;
  logic fall;
  logic fin;
  logic sel_dram;
  logic sel_burst;
  logic [2:0] area_wait;
  logic [15:0] rd_mux;
  logic [19:0] rd_idx;
  logic [19:0] wr_idx;
  logic [15:0] wdat;

  always_comb begin
    st_next = st_reg;
    standby = st_reg.mode_control[`B_DEEP_HALT] | st_reg.mode_control[`B_SLEEP];
    remap = st_reg.mode_control[`B_REMAP];
    ref_on = st_reg.bus_control[`B_REF_ON];
    ref_self = st_reg.bus_control[`B_REF_SELF];
    ext_master = st_reg.bus_control[`B_EXT_MASTER];
    fall = st_reg.div;
    fin = 1'b0;
    sel_dram = 1'b0;
    sel_burst = 1'b0;
    area_wait = `AREA_WAIT_OTHER;
    rd_idx = st_reg.ahb_addr[21:2];
    wr_idx = st_reg.ahb_addr[21:2];
    wdat = hwdata[15:0];
    rd_mux = 16'h0000;
    st_next.acc_done = 1'b0;
    // Register file; unmapped addresses read zero and ignore writes.
    if (st_reg.ahb_addr[31:22] == 10'h000 && st_reg.ahb_addr[1:0] == 2'h0) begin
      case (rd_idx)
        `IDX_AREAS_14_13: rd_mux = st_reg.areas_14_13_setup;
        `IDX_AREAS_10_9: rd_mux = st_reg.areas_10_9_setup;
        `IDX_AREAS_8_7: rd_mux = st_reg.areas_8_7_setup;
        `IDX_BUS_CONTROL: rd_mux = st_reg.bus_control; // R10 R15
        `IDX_MODE_CONTROL: rd_mux = st_reg.mode_control;
        `IDX_ENGINE_STATUS: rd_mux = {9'h000, st_reg.state, st_reg.ref_pend,
                                      ~st_reg.grant_n, st_reg.cpu_halt, st_reg.wait_f};
        default: rd_mux = 16'h0000;
      endcase
      if (st_reg.ahb_wr) begin
        case (wr_idx)
          `IDX_AREAS_14_13: st_next.areas_14_13_setup = wdat & `MASK_AREAS_14_13;
          `IDX_AREAS_10_9: st_next.areas_10_9_setup = wdat & `MASK_AREAS_10_9;
          `IDX_AREAS_8_7: st_next.areas_8_7_setup = wdat & `MASK_AREAS_8_7;
          `IDX_BUS_CONTROL: st_next.bus_control = wdat & `MASK_BUS_CONTROL;
          `IDX_MODE_CONTROL: st_next.mode_control = wdat & `MASK_MODE_CONTROL;
          default: st_next.ahb_wr = 1'b0;
        endcase
      end
    end
    st_next.ahb_wr = 1'b0;
    // Reads take one wait state so a write just before is already visible.
    if (st_reg.ahb_rd) begin
      st_next.hrdata = {16'h0000, rd_mux};
      st_next.hreadyout = 1'b1;
      st_next.ahb_rd = 1'b0;
    end
    if (hsel && htrans[1] && hready) begin
      st_next.ahb_addr = haddr;
      st_next.ahb_wr = hwrite;
      st_next.ahb_rd = ~hwrite;
      if (!hwrite) begin
        st_next.hreadyout = 1'b0;
      end
    end
    st_next.hresp = 1'b0;

    // Pins from outside pass three flops; a change counts once the last two agree.
    st_next.wait_sync = {st_reg.wait_sync[1:0], wait_n};
    if (st_reg.wait_sync[1] == st_reg.wait_sync[2]) begin
      st_next.wait_f = st_reg.wait_sync[2];
    end
    st_next.breq_sync = {st_reg.breq_sync[1:0], bus_request_n};
    if (st_reg.breq_sync[1] == st_reg.breq_sync[2]) begin
      st_next.breq_f = st_reg.breq_sync[2];
    end

    st_next.div = ~st_reg.div;
    st_next.bus_clock_out = (st_reg.bus_control[`B_BCLK_HOLD] | standby) ? 1'b1
                                                                       : st_next.div; // R07
    st_next.cpu_halt = st_reg.bus_control[`B_EXT_PD] & ~st_reg.breq_f; // R18
    st_next.edo = st_reg.bus_control[`B_EDO]; // R09
    st_next.col_width = `COL_BASE + {2'h0, st_reg.bus_control[`F_COL]}; // R10

    // Area decode of the pending request.
    case (acc_area)
      `AREA_13, `AREA_14: begin
        area_wait = st_reg.areas_14_13_setup[`F_AREA_WAIT];
        sel_dram = remap & st_reg.areas_14_13_setup[(acc_area == `AREA_14) ? `B_SEL_HI
                                                                           : `B_SEL_LO]; // R04
      end
      `AREA_9, `AREA_10: begin
        area_wait = st_reg.areas_10_9_setup[`F_AREA_WAIT];
        sel_burst = (acc_area == `AREA_10) ? st_reg.areas_10_9_setup[`B_SEL_HI]
                  : (~remap & st_reg.areas_10_9_setup[`B_SEL_LO]); // R05
      end
      `AREA_7, `AREA_8: begin
        area_wait = st_reg.areas_8_7_setup[`F_AREA_WAIT];
        sel_dram = ~remap & st_reg.areas_8_7_setup[(acc_area == `AREA_8) ? `B_SEL_HI
                                                                          : `B_SEL_LO]; // R04
      end
      default: area_wait = `AREA_WAIT_OTHER;
    endcase

    case (st_reg.state)
      bus_control_unit_pkg::S_IDLE: begin
        if (!st_reg.grant_n) begin
          if (st_reg.breq_f || !ext_master) begin
            st_next.grant_n = 1'b1;
          end
        end else if (st_reg.ref_pend && ref_on && !ref_self && !standby) begin
          st_next.state = bus_control_unit_pkg::S_RDLY; // R12 R25
          st_next.ref_pend = 1'b0;
          st_next.cnt = {3'h0, st_reg.bus_control[`B_REF_DELAY]}; // R14
        end else if (ref_on && ref_self && !standby) begin
          st_next.state = bus_control_unit_pkg::S_SELF; // R13
          st_next.cas_n = 1'b0;
          st_next.ras_n = 1'b0;
        end else if (ext_master && !st_reg.breq_f) begin
          st_next.grant_n = 1'b0; // R17
        end else if (acc_req && !st_reg.acc_done) begin
          st_next.state = bus_control_unit_pkg::S_ACC;
          st_next.is_dram = sel_dram;
          st_next.is_burst = sel_burst;
          st_next.is_write = acc_write;
          // DRAM never waits; burst ROM reads never use the wait pin.
          st_next.ext_ok = st_reg.bus_control[`B_WAIT_ON] & ~sel_dram
                         & (~sel_burst | acc_write); // R02 R23 R24
          st_next.cnt = sel_dram ? 4'h0 : {1'b0, area_wait}; // R02 R22 R23
          st_next.rd_n = acc_write;
          st_next.wr_n = ~acc_write;
          st_next.ras_n = ~sel_dram;
          st_next.cas_n = ~sel_dram;
          st_next.byte_sel_n = ~(st_reg.bus_control[`B_BYTE_SEL] & ~sel_dram
                          & acc_low_byte); // R16
        end
      end
      bus_control_unit_pkg::S_ACC: begin
        if (st_reg.cnt != 4'h0) begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end else if (st_reg.ext_ok && !st_reg.wait_f) begin
          st_next.state = bus_control_unit_pkg::S_XWAIT; // R19
        end else if (st_reg.is_burst && !st_reg.is_write) begin
          st_next.state = bus_control_unit_pkg::S_BURST;
          st_next.cnt = {2'h0, st_reg.areas_10_9_setup[`F_BURST_WAIT]}; // R01 R06
          st_next.beats = st_reg.bus_control[`B_BURST8] ? `BEATS_8 : `BEATS_4; // R08
        end else begin
          fin = 1'b1;
        end
      end
      bus_control_unit_pkg::S_XWAIT: begin
        // The wait pin is looked at only on a falling bus clock edge.
        if (fall && st_reg.wait_f) begin
          fin = 1'b1; // R19
        end
      end
      bus_control_unit_pkg::S_BURST: begin
        if (st_reg.cnt != 4'h0) begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end else if (st_reg.beats == 3'h0) begin
          fin = 1'b1;
        end else begin
          st_next.beats = st_reg.beats - 3'h1; // R08
          st_next.cnt = {2'h0, st_reg.areas_10_9_setup[`F_BURST_WAIT]}; // R01 R06
        end
      end
      bus_control_unit_pkg::S_RDLY: begin
        if (st_reg.cnt != 4'h0) begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end else begin
          st_next.state = bus_control_unit_pkg::S_RRAS;
          st_next.cas_n = 1'b0; // R14
          st_next.cnt = `RAS_W_BASE + {2'h0, st_reg.bus_control[`F_RAS_W]}; // R15
        end
      end
      bus_control_unit_pkg::S_RRAS: begin
        if (st_reg.cnt != 4'h0) begin
          st_next.ras_n = 1'b0; // R15
          st_next.cnt = st_reg.cnt - 4'h1;
        end else begin
          st_next.state = bus_control_unit_pkg::S_IDLE;
          st_next.ras_n = 1'b1;
          st_next.cas_n = 1'b1;
        end
      end
      bus_control_unit_pkg::S_SELF: begin
        if (!ref_on) begin
          st_next.state = bus_control_unit_pkg::S_IDLE; // R13
          st_next.ras_n = 1'b1;
          st_next.cas_n = 1'b1;
        end
      end
      default: st_next.state = bus_control_unit_pkg::S_IDLE;
    endcase

    if (fin) begin
      st_next.state = bus_control_unit_pkg::S_IDLE;
      st_next.acc_done = 1'b1;
      st_next.rd_n = 1'b1;
      st_next.wr_n = 1'b1;
      st_next.ras_n = 1'b1;
      st_next.cas_n = 1'b1;
      st_next.byte_sel_n = 1'b1;
    end

    // A timer pulse arriving while the flag is taken still sets it again.
    if (!ref_on) begin
      st_next.ref_pend = 1'b0; // R11
    end
    if (timer0_underflow && ref_on && !ref_self && !standby) begin
      st_next.ref_pend = 1'b1; // R11 R12 R25
    end

    // Hot start stops the engine but keeps every setting.
    if (hot_start) begin
      st_next.state = bus_control_unit_pkg::S_IDLE;
      st_next.ref_pend = 1'b0;
      st_next.grant_n = 1'b1;
      st_next.acc_done = 1'b0;
      st_next.rd_n = 1'b1;
      st_next.wr_n = 1'b1;
      st_next.ras_n = 1'b1;
      st_next.cas_n = 1'b1;
      st_next.byte_sel_n = 1'b1; // R03 R21
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= COLD; // R03 R21
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata = st_reg.hrdata;
  assign hreadyout = st_reg.hreadyout;
  assign hresp = st_reg.hresp;
  assign acc_done = st_reg.acc_done;
  assign bus_grant_n = st_reg.grant_n;
  assign cpu_halt = st_reg.cpu_halt;
  assign bus_clock_out = st_reg.bus_clock_out;
  assign ras_n = st_reg.ras_n;
  assign cas_n = st_reg.cas_n;
  assign mem_rd_n = st_reg.rd_n;
  assign mem_wr_n = st_reg.wr_n;
  assign byte_select_low_n = st_reg.byte_sel_n;
  assign edo_page_select = st_reg.edo;
  assign column_addr_width = st_reg.col_width;

  // Helper counters read only by the checks below.
  logic [3:0] ras_low_reg;
  logic [3:0] acc_cyc_reg;
  logic [3:0] acc_wait_reg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ras_low_reg <= 4'h0;
      acc_cyc_reg <= 4'h0;
      acc_wait_reg <= 4'h0;
    end else begin
      ras_low_reg <= ras_n ? 4'h0 : ras_low_reg + 4'h1;
      acc_cyc_reg <= (st_reg.state == bus_control_unit_pkg::S_ACC) ? acc_cyc_reg + 4'h1 : 4'h0;
      if (st_reg.state == bus_control_unit_pkg::S_IDLE) begin
        acc_wait_reg <= st_next.cnt;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  a_bclk_held_high: assert property ( // R07
    (st_reg.bus_control[`B_BCLK_HOLD] || standby) |=> bus_clock_out)
    else $error("Bus clock not held high.");
  a_refresh_gated: assert property ( // R11
    $rose(st_reg.state == bus_control_unit_pkg::S_RDLY) |-> $past(ref_on && !standby))
    else $error("Refresh started while disabled or in standby.");
  a_cas_delay_one: assert property ( // R14
    ($rose(st_reg.state == bus_control_unit_pkg::S_RDLY)
      && !st_reg.bus_control[`B_REF_DELAY]) |-> ##1 $fell(cas_n))
    else $error("CAS did not fall one cycle after precharge.");
  a_cas_delay_two: assert property ( // R14
    ($rose(st_reg.state == bus_control_unit_pkg::S_RDLY)
      && st_reg.bus_control[`B_REF_DELAY]) |-> cas_n ##1 cas_n ##1 !cas_n)
    else $error("CAS did not fall two cycles after precharge.");
  a_ras_pulse_width: assert property ( // R15
    ($rose(ras_n) && $past(st_reg.state) == bus_control_unit_pkg::S_RRAS)
      |-> $past(ras_low_reg) + 4'h1 == `RAS_W_BASE + {2'h0, st_reg.bus_control[`F_RAS_W]})
    else $error("Refresh RAS pulse width wrong.");
  a_dram_no_wait: assert property ( // R23
    ($rose(st_reg.state == bus_control_unit_pkg::S_ACC) && st_reg.is_dram) |=> acc_done)
    else $error("DRAM access delayed by waits.");
  a_wait_disabled: assert property ( // R24
    ($rose(st_reg.state == bus_control_unit_pkg::S_ACC)
      && !$past(st_reg.bus_control[`B_WAIT_ON])) |-> !st_reg.ext_ok)
    else $error("Wait pin honoured while disabled.");
  a_sram_wait_count: assert property ( // R22
    (acc_done && $past(st_reg.state) == bus_control_unit_pkg::S_ACC
      && !$past(st_reg.is_dram) && !$past(st_reg.is_burst) && !$past(st_reg.ext_ok))
      |-> $past(acc_cyc_reg) == acc_wait_reg)
    else $error("SRAM wait count wrong.");
  a_grant_needs_master: assert property ( // R17
    $fell(bus_grant_n) |-> $past(ext_master))
    else $error("Bus granted without external master enabled.");
  a_refresh_kept: assert property ( // R25
    (timer0_underflow && ref_on && !ref_self && !standby) |=> st_reg.ref_pend)
    else $error("Refresh request dropped.");
  c_sram_access: cover property (acc_done && !$past(st_reg.is_dram));
  c_cbr_refresh: cover property ($rose(st_reg.state == bus_control_unit_pkg::S_RRAS));
  c_self_refresh: cover property ($rose(st_reg.state == bus_control_unit_pkg::S_SELF));
  c_bus_grant: cover property ($fell(bus_grant_n));
endmodule

// ---- bus_control_unit_defines.svh ----
// Register indices, field positions, reset values and counts of the bus control unit.
// Assumes inclusion by bare name from the design module and the bench.
`ifndef BUS_CONTROL_UNIT_DEFINES_SVH
`define BUS_CONTROL_UNIT_DEFINES_SVH
`define IDX_AREAS_14_13 20'h4_8122
`define IDX_AREAS_10_9 20'h4_8126
`define IDX_AREAS_8_7 20'h4_8128
`define IDX_BUS_CONTROL 20'h4_812E
`define IDX_MODE_CONTROL 20'h4_8140
`define IDX_ENGINE_STATUS 20'h4_8142
`define MASK_AREAS_14_13 16'h0187
`define MASK_AREAS_10_9 16'h0787
`define MASK_AREAS_8_7 16'h0187
`define MASK_BUS_CONTROL 16'hBFEF
`define MASK_MODE_CONTROL 16'h0007
`define RST_AREA 16'h0007
`define RST_BUS_CONTROL 16'h0000
`define RST_MODE_CONTROL 16'h0000
`define B_SEL_HI 8
`define B_SEL_LO 7
`define F_AREA_WAIT 2:0
`define F_BURST_WAIT 10:9
`define B_BCLK_HOLD 15
`define B_BURST8 13
`define B_EDO 12
`define F_COL 11:10
`define B_REF_ON 9
`define B_REF_SELF 8
`define B_REF_DELAY 7
`define F_RAS_W 6:5
`define B_BYTE_SEL 3
`define B_EXT_MASTER 2
`define B_EXT_PD 1
`define B_WAIT_ON 0
`define B_REMAP 0
`define B_DEEP_HALT 1
`define B_SLEEP 2
`define COL_BASE 4'h8
`define RAS_W_BASE 4'h2
// One less than the beats that follow the first access of a burst, counted down to zero.
`define BEATS_4 3'h2
`define BEATS_8 3'h6
`define AREA_WAIT_OTHER 3'h7
`define AREA_7 5'h07
`define AREA_8 5'h08
`define AREA_9 5'h09
`define AREA_10 5'h0A
`define AREA_13 5'h0D
`define AREA_14 5'h0E
`endif

// ---- bus_control_unit_pkg.sv ----
// Types shared by the bus control unit: engine states and the packed state record.
// Assumes the defines header is compiled first.
package bus_control_unit_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ACC = 3'h1,
    S_XWAIT = 3'h3,
    S_BURST = 3'h2,
    S_RDLY = 3'h6,
    S_RRAS = 3'h7,
    S_SELF = 3'h4
  } engine_state_t;

  typedef struct packed {
    logic [15:0] areas_14_13_setup;
    logic [15:0] areas_10_9_setup;
    logic [15:0] areas_8_7_setup;
    logic [15:0] bus_control;
    logic [15:0] mode_control;
    engine_state_t state;
    logic [3:0] cnt;
    logic [2:0] beats;
    logic is_dram;
    logic is_burst;
    logic is_write;
    logic ext_ok;
    logic ref_pend;
    logic [2:0] wait_sync;
    logic wait_f;
    logic [2:0] breq_sync;
    logic breq_f;
    logic div;
    logic ahb_wr;
    logic ahb_rd;
    logic [31:0] ahb_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic bus_clock_out;
    logic ras_n;
    logic cas_n;
    logic rd_n;
    logic wr_n;
    logic byte_sel_n;
    logic grant_n;
    logic cpu_halt;
    logic acc_done;
    logic edo;
    logic [3:0] col_width;
  } unit_state_t;
endpackage

// ---- bus_control_unit_tb_top.sv ----
// Bench for the bus control unit: registers, access timing, refresh, clock and bus request.
// Assumes the defines header and the external memory model that drives the wait line.
`include "bus_control_unit_defines.svh"
module bus_control_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic hot_start = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic acc_req = 1'b0;
  logic acc_write = 1'b0;
  logic [4:0] acc_area = 5'h00;
  logic timer0_underflow = 1'b0;
  logic bus_request_n = 1'b1;
  logic [3:0] slow_cycles = 4'h0;
  logic [31:0] hrdata;
  logic [3:0] column_addr_width;
  logic hreadyout, hresp, acc_done, wait_n, bus_grant_n, cpu_halt, bus_clock_out;
  logic ras_n, cas_n, mem_rd_n, mem_wr_n, byte_select_low_n, edo_page_select;
  logic [31:0] d;
  logic [15:0] w;
  logic low_seen;
  logic hi;
  int n;
  int tc;
  int tr;
  int base;
  int miscompares = 0;
  int check_count = 0;

  always #25 clock = ~clock;

  bus_control_unit bus_control_unit_inst (
    .clock(clock), .arst_n(arst_n), .hot_start(hot_start), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .acc_req(acc_req),
    .acc_area(acc_area), .acc_write(acc_write), .acc_low_byte(1'b1), .acc_done(acc_done),
    .timer0_underflow(timer0_underflow), .wait_n(wait_n), .bus_request_n(bus_request_n),
    .bus_grant_n(bus_grant_n), .cpu_halt(cpu_halt), .bus_clock_out(bus_clock_out),
    .ras_n(ras_n), .cas_n(cas_n), .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n),
    .byte_select_low_n(byte_select_low_n), .edo_page_select(edo_page_select),
    .column_addr_width(column_addr_width));

  ext_mem_model ext_mem_model_inst (.clock(clock), .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n),
    .slow_cycles(slow_cycles), .wait_n(wait_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [19:0] idx, input logic [15:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {10'h000, idx, 2'h0};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, wd};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    d = hrdata;
  endtask

  task automatic access(input logic [4:0] area, input logic wr);
    @(posedge clock);
    acc_req <= 1'b1;
    acc_area <= area;
    acc_write <= wr;
    n = 0;
    low_seen = 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (byte_select_low_n === 1'b0) low_seen = 1'b0;
    end while (acc_done !== 1'b1 && n < 200);
    acc_req <= 1'b0;
  endtask

  // Counts edges to the CAS fall and the edges that see RAS low.
  task automatic refresh;
    @(posedge clock);
    timer0_underflow <= 1'b1;
    @(posedge clock);
    timer0_underflow <= 1'b0;
    tc = 0;
    tr = 0;
    while (cas_n !== 1'b0 && tc < 30) begin
      @(posedge clock);
      tc++;
    end
    for (int i = 0; i < 30 && ras_n !== 1'b0; i++) @(posedge clock);
    while (ras_n === 1'b0 && tr < 30) begin
      @(posedge clock);
      tr++;
    end
  endtask

  task automatic level;
    hi = 1'b1;
    // The pin lags a register write by one cycle, so one edge passes first.
    @(posedge clock);
    repeat (4) begin
      @(posedge clock);
      hi = hi & bus_clock_out;
    end
  endtask

  task automatic finish_test;
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The sequence needs well under a thousand cycles, so twenty thousand can only mean a hang.
  initial begin
    #(20000 * 50);
    miscompares++;
    finish_test;
  end

  initial begin
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    bus(1'b0, `IDX_AREAS_8_7, 16'h0000);
    check(d, 32'h0000_0007);
    bus(1'b0, `IDX_BUS_CONTROL, 16'h0000);
    check(d, 32'h0000_0000);
    bus(1'b1, 20'h4_8130, 16'hFFFF);
    bus(1'b0, 20'h4_8130, 16'h0000);
    check(d, 32'h0000_0000);
    check(hresp, 1'b0);
    // Method bit stays clear while refresh is enabled; reserved bits are written as ones.
    for (logic [2:0] k = 3'h0; k < 3'h4; k++) begin
      w = {4'h4, k[1:0], 1'b1, 1'b0, k[0], k[1:0], 1'b1, 4'h0};
      bus(1'b1, `IDX_BUS_CONTROL, w);
      bus(1'b0, `IDX_BUS_CONTROL, 16'h0000);
      check(d, {16'h0000, w & 16'hBFEF});
      check(column_addr_width, 4'h8 + k[1:0]);
      refresh();
      check(tr, 3'h2 + k);
      if (k == 3'h0) base = tc;
      check(tc, base + k[0]);
    end
    bus(1'b1, `IDX_BUS_CONTROL, 16'h1000);
    bus(1'b1, `IDX_AREAS_8_7, 16'h0085);
    @(posedge clock);
    hot_start <= 1'b1;
    @(posedge clock);
    hot_start <= 1'b0;
    check(edo_page_select, 1'b1);
    bus(1'b0, `IDX_AREAS_8_7, 16'h0000);
    check(d, 32'h0000_0085);
    bus(1'b0, `IDX_BUS_CONTROL, 16'h0000);
    check(d, 32'h0000_1000);
    access(5'h07, 1'b0);
    check(n, 3);
    access(5'h08, 1'b0);
    check(n, 8);
    access(5'h05, 1'b1);
    check(n, 10);
    slow_cycles <= 4'hC;
    bus(1'b1, `IDX_BUS_CONTROL, 16'h0009);
    access(5'h08, 1'b0);
    check(n > 10 && n < 30, 1'b1);
    check(low_seen, 1'b0);
    access(5'h07, 1'b1);
    check(n, 3);
    bus(1'b1, `IDX_BUS_CONTROL, 16'h0000);
    access(5'h08, 1'b1);
    check(n, 8);
    check(low_seen, 1'b1);
    slow_cycles <= 4'h0;
    bus(1'b1, `IDX_AREAS_10_9, 16'h0503);
    access(5'h0A, 1'b0);
    check(n, 15);
    bus(1'b1, `IDX_BUS_CONTROL, 16'h2000);
    access(5'h0A, 1'b0);
    check(n, 27);
    access(5'h0A, 1'b1);
    check(n, 6);
    access(5'h09, 1'b0);
    check(n, 6);
    bus(1'b1, `IDX_BUS_CONTROL, 16'h0200);
    fork
      access(5'h05, 1'b0);
      begin
        repeat (4) @(posedge clock);
        timer0_underflow <= 1'b1;
        @(posedge clock);
        timer0_underflow <= 1'b0;
      end
    join
    check(n, 10);
    for (n = 0; n < 20 && ras_n !== 1'b0; n++) @(posedge clock);
    check(n < 20, 1'b1);
    bus(1'b1, `IDX_BUS_CONTROL, 16'h0100);
    bus(1'b1, `IDX_BUS_CONTROL, 16'h0300);
    bus(1'b0, `IDX_ENGINE_STATUS, 16'h0000);
    check(d[6:4], 3'h4);
    bus(1'b1, `IDX_BUS_CONTROL, 16'h0000);
    access(5'h05, 1'b0);
    check(n < 30, 1'b1);
    level();
    check(hi, 1'b0);
    bus(1'b1, `IDX_BUS_CONTROL, 16'h8000);
    level();
    check(hi, 1'b1);
    bus(1'b1, `IDX_BUS_CONTROL, 16'h0200);
    bus(1'b1, `IDX_MODE_CONTROL, 16'h0002);
    level();
    check(hi, 1'b1);
    refresh();
    check(tr, 0);
    bus(1'b1, `IDX_BUS_CONTROL, 16'h0002);
    bus(1'b1, `IDX_MODE_CONTROL, 16'h0000);
    bus_request_n <= 1'b0;
    repeat (8) @(posedge clock);
    check(bus_grant_n, 1'b1);
    check(cpu_halt, 1'b1);
    bus(1'b1, `IDX_BUS_CONTROL, 16'h0004);
    repeat (8) @(posedge clock);
    check(bus_grant_n, 1'b0);
    check(cpu_halt, 1'b0);
    bus_request_n <= 1'b1;
    repeat (8) @(posedge clock);
    check(bus_grant_n, 1'b1);
    finish_test;
  end
endmodule

// ---- ext_mem_model.sv ----
// Model of the external SRAM, DRAM and burst ROM devices on the far side of the unit.
// Assumes active-low strobes from the unit and a bench-set count of wait cycles.
module ext_mem_model (
  input wire logic clock,
  input wire logic mem_rd_n,
  input wire logic mem_wr_n,
  input wire logic [3:0] slow_cycles,
  output logic wait_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy = 1'b0;
  logic [3:0] left = 4'h0;
  // A slow device pulls its wait line low at the start of a cycle and lets go once ready.
  always @(posedge clock) begin
    if (mem_rd_n && mem_wr_n) begin
      busy <= 1'b0;
      wait_n <= 1'b1;
    end else if (!busy) begin
      busy <= 1'b1;
      left <= slow_cycles;
      wait_n <= (slow_cycles == 4'h0);
    end else if (left > 4'h1) begin
      left <= left - 4'h1;
    end else begin
      wait_n <= 1'b1;
    end
  end
endmodule
